// >>> hdl/ldcr_regs.svh
`ifndef LDCR_REGS_SVH
`define LDCR_REGS_SVH

// Seven-bit register addresses: bank bit then six address bits.
`define LDCR_ADDR_SPREAD 7'h05
`define LDCR_ADDR_DVC 7'h06
`define LDCR_ADDR_FSS_CH0 7'h09
`define LDCR_ADDR_FSD_CH0 7'h0A
`define LDCR_ADDR_MON_CH0 7'h0C
`define LDCR_ADDR_FSS_CH1 7'h48
`define LDCR_ADDR_FSD_CH1 7'h4B
`define LDCR_ADDR_MON_CH1 7'h4D

// Reset values.
`define LDCR_RST_SPREAD 8'h04
`define LDCR_RST_DVC 8'h00
`define LDCR_RST_FSS 8'h02
`define LDCR_RST_FSD 8'h80
`define LDCR_RST_MON 8'h00

// Field positions.
`define LDCR_B_DEV 0
`define LDCR_B_RATE 1
`define LDCR_B_SPEN 2
`define LDCR_B_IDLE 0
`define LDCR_B_SRST 1
`define LDCR_B_CLRL 2
`define LDCR_B_FSDONE 4
`define LDCR_B_FSSTART 5
`define LDCR_B_CUT 6
`define LDCR_B_MDONE 2
`define LDCR_B_MSTART 3
`define LDCR_B_PINSEL 4

// Decoded figures.
`define LDCR_DEV_WIDE 5'h14
`define LDCR_DEV_NARROW 5'h0A
`define LDCR_FM_SLOW 5'h0C
`define LDCR_FM_FAST 5'h12
`define LDCR_STEPS_MAX 5'h10
`define LDCR_FRAME_BITS 5'h10
`endif

// >>> hdl/ldcr_pkg.sv
package ldcr_pkg;
	typedef enum logic [1:0]
	{
		LDCR_ST_IDLE = 2'h0,
		LDCR_ST_SHIFT = 2'h1,
		LDCR_ST_END = 2'h3
	} ldcr_spi_st_t;
	typedef logic [7:0] ldcr_byte_t;
endpackage : ldcr_pkg

// >>> hdl/ldcr_cfg_if.sv
interface ldcr_cfg_if;
	import ldcr_pkg::*;
	logic wr_setup;
	logic wr_delay;
	logic wr_mon;
	logic srst;
	ldcr_byte_t wdata;
	ldcr_byte_t rd_setup;
	ldcr_byte_t rd_delay;
	ldcr_byte_t rd_mon;
	modport host (output wr_setup, wr_delay, wr_mon, srst, wdata,
		input rd_setup, rd_delay, rd_mon);
	modport chan (input wr_setup, wr_delay, wr_mon, srst, wdata,
		output rd_setup, rd_delay, rd_mon);
endinterface : ldcr_cfg_if

// >>> hdl/ldcr_spi_slave.sv
`include "ldcr_regs.svh"
module ldcr_spi_slave
	import ldcr_pkg::*;
(
	input wire logic i_clk_sys, // System clock.
	input wire logic i_nrst, // Asynchronous reset, active low.
	input wire logic i_sclk, // Serial clock pin.
	input wire logic i_csn, // Chip select pin, active low.
	input wire logic i_sdi, // Serial data in.
	input wire logic [15:0] i_tx_word, // Word sent in next frame.
	output logic o_sdo, // Serial data out.
	output logic o_sdo_oe, // Data out enable.
	output logic o_frame_valid, // One-cycle pulse, frame complete.
	output logic [15:0] o_frame_word // Received frame.
);
	ldcr_spi_st_t state_ff;
	ldcr_spi_st_t nxt_state;
	logic sclk_d_ff;
	logic csn_d_ff;
	logic [4:0] cnt_ff;
	logic [15:0] rx_ff;
	logic [15:0] tx_ff;
	logic valid_ff;
	wire sclk_rise = i_sclk & ~sclk_d_ff;
	wire sclk_fall = ~i_sclk & sclk_d_ff;
	wire cs_fall = ~i_csn & csn_d_ff;
	wire cs_rise = i_csn & ~csn_d_ff;
	wire in_shift = (state_ff == LDCR_ST_SHIFT);
	wire full = (cnt_ff == `LDCR_FRAME_BITS);

	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			LDCR_ST_IDLE: if (cs_fall) nxt_state = LDCR_ST_SHIFT;
			LDCR_ST_SHIFT: if (cs_rise) nxt_state = LDCR_ST_END;
			LDCR_ST_END: nxt_state = LDCR_ST_IDLE;
			default: nxt_state = LDCR_ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			state_ff <= LDCR_ST_IDLE;
			sclk_d_ff <= 1'b0;
			csn_d_ff <= 1'b1;
			cnt_ff <= 5'h00;
			rx_ff <= 16'h0000;
			tx_ff <= 16'h0000;
			valid_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			sclk_d_ff <= i_sclk;
			csn_d_ff <= i_csn;
			// A frame with the wrong bit count is dropped here.
			valid_ff <= in_shift & cs_rise & full;
			if (cs_fall)
			begin
				cnt_ff <= 5'h00;
				tx_ff <= i_tx_word;
			end
			else if (in_shift & sclk_rise)
			begin
				rx_ff <= {rx_ff[14:0], i_sdi};
				// Counting past sixteen lets a long frame be dropped.
				if (cnt_ff != 5'h1F) cnt_ff <= cnt_ff + 5'h01;
			end
			else if (in_shift & sclk_fall)
				tx_ff <= {tx_ff[14:0], 1'b0};
		end
	end

	assign o_sdo = tx_ff[15];
	assign o_sdo_oe = in_shift;
	assign o_frame_valid = valid_ff;
	assign o_frame_word = rx_ff;

	frame_count_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		valid_ff |-> $past(cnt_ff) == `LDCR_FRAME_BITS)
		else $error("Frame accepted with wrong bit count.");
endmodule : ldcr_spi_slave

// >>> hdl/ldcr_channel.sv
`include "ldcr_regs.svh"
module ldcr_channel
	import ldcr_pkg::*;
(
	input wire logic i_clk_sys, // System clock.
	input wire logic i_nrst, // Asynchronous reset, active low.
	ldcr_cfg_if.chan bus, // Register access from the top.
	input wire logic i_fs_done, // Float-switch routine finished.
	input wire logic i_mon_done, // Monitor routine succeeded.
	input wire logic [1:0] i_band, // Load current band.
	output logic o_fs_start, // Pulse: start float-switch routine.
	output logic o_fs_running, // Float-switch routine active.
	output logic o_mon_start, // Pulse: start monitor routine.
	output logic o_amp_cut, // Amplifier current cut to 20%.
	output logic [4:0] o_chain_steps, // Decoded step count 1..16.
	output logic [7:0] o_fs_delay, // Float-switch delay code.
	output logic o_pin_is_mon // Shared pin outputs current monitor.
);
	logic [7:0] setup_ff;
	logic [7:0] delay_ff;
	logic [4:0] mon_ff;
	logic [1:0] band_ff;
	logic fs_start_ff;
	logic mon_start_ff;
	wire fs_go = bus.wr_setup & bus.wdata[`LDCR_B_FSSTART];
	wire mon_go = bus.wr_mon & bus.wdata[`LDCR_B_MSTART];
	wire fs_run = setup_ff[`LDCR_B_FSSTART];
	wire mon_run = mon_ff[`LDCR_B_MSTART];
	// Done wins over the clearing start so no completion is lost.
	wire nxt_fs_done = (fs_run & i_fs_done) |
		(setup_ff[`LDCR_B_FSDONE] & ~fs_go);
	wire nxt_mon_done = (mon_run & i_mon_done) |
		(mon_ff[`LDCR_B_MDONE] & ~mon_go);
	wire nxt_fs_run = fs_go | (fs_run & ~i_fs_done);
	wire nxt_mon_run = mon_go | (mon_run & ~i_mon_done);

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			setup_ff <= `LDCR_RST_FSS;
			delay_ff <= `LDCR_RST_FSD;
			mon_ff <= 5'(`LDCR_RST_MON);
			band_ff <= 2'h0;
			fs_start_ff <= 1'b0;
			mon_start_ff <= 1'b0;
		end
		else if (bus.srst)
		begin
			setup_ff <= `LDCR_RST_FSS;
			delay_ff <= `LDCR_RST_FSD;
			mon_ff <= 5'(`LDCR_RST_MON);
			band_ff <= 2'h0;
			fs_start_ff <= 1'b0;
			mon_start_ff <= 1'b0;
		end
		else
		begin
			band_ff <= i_band;
			fs_start_ff <= fs_go & ~fs_run;
			mon_start_ff <= mon_go & ~mon_run;
			setup_ff <= {1'b0,
				bus.wr_setup ? bus.wdata[`LDCR_B_CUT] :
				setup_ff[`LDCR_B_CUT],
				nxt_fs_run, nxt_fs_done,
				bus.wr_setup ? bus.wdata[3:0] : setup_ff[3:0]};
			if (bus.wr_delay) delay_ff <= bus.wdata;
			mon_ff <= {bus.wr_mon ? bus.wdata[`LDCR_B_PINSEL] :
				mon_ff[`LDCR_B_PINSEL],
				nxt_mon_run, nxt_mon_done, band_ff};
		end
	end

	assign bus.rd_setup = setup_ff;
	assign bus.rd_delay = delay_ff;
	assign bus.rd_mon = {3'h0, mon_ff};
	assign o_fs_start = fs_start_ff;
	assign o_mon_start = mon_start_ff;
	assign o_fs_running = fs_run;
	assign o_amp_cut = setup_ff[`LDCR_B_CUT] & fs_run;
	assign o_chain_steps = (setup_ff[3:0] == 4'h0) ? `LDCR_STEPS_MAX :
		{1'b0, setup_ff[3:0]};
	assign o_fs_delay = delay_ff;
	assign o_pin_is_mon = mon_ff[`LDCR_B_PINSEL];

	amp_cut_gate_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst) o_amp_cut |-> o_fs_running)
		else $error("Amplifier cut outside float-switch routine.");
	mon_done_clr_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		(mon_go & ~i_mon_done & ~bus.srst) |=> !bus.rd_mon[2])
		else $error("Monitor done not cleared by start.");
	fs_done_set_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		(fs_run & i_fs_done & ~fs_go & ~bus.srst) |=>
		setup_ff[4] && !fs_run)
		else $error("Float-switch done not set on completion.");
	steps_zero_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		(setup_ff[3:0] == 4'h0) |-> o_chain_steps == 5'h10)
		else $error("Step code zero must give sixteen steps.");
	delay_write_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		(bus.wr_delay & ~bus.srst) |=> delay_ff == $past(bus.wdata))
		else $error("Delay write not stored.");
endmodule : ldcr_channel

// >>> hdl/ldcr_top.sv
`include "ldcr_regs.svh"
module ldcr_top
	import ldcr_pkg::*;
#(
	parameter int NCH = 2 // Number of channels.
)
(
	input wire logic i_clk_sys, // System clock, 10 MHz.
	input wire logic i_nrst, // Asynchronous reset, active low.
	input wire logic i_sclk, // Serial clock pin.
	input wire logic i_csn, // Chip select pin, active low.
	input wire logic i_sdi, // Serial data in.
	output logic o_sdo, // Serial data out.
	output logic o_sdo_oe, // Serial data out enable.
	input wire logic [7:0] i_std_diag, // Standard diagnosis byte.
	output logic o_spread_en, // Spread spectrum active.
	output logic [4:0] o_spread_dev_pct, // Deviation in percent.
	output logic [4:0] o_spread_fm_khz, // Modulation rate in kHz.
	output logic o_idle, // Idle mode.
	output logic o_soft_reset, // Pulse: device soft reset.
	output logic o_clear_latch, // Pulse: clear-latch command.
	input wire logic [NCH-1:0] i_fs_done, // Float-switch routine done.
	input wire logic [NCH-1:0] i_mon_done, // Monitor routine success.
	input wire logic [NCH-1:0][1:0] i_band, // Load current band.
	input wire logic [NCH-1:0] i_ov_event, // Overvoltage detected.
	input wire logic [NCH-1:0] i_ov_latch_en, // Overvoltage latching.
	input wire logic [NCH-1:0] i_topology_pin, // Topology pin level.
	input wire logic [NCH-1:0] i_short_det, // Short to ground seen.
	output logic [NCH-1:0] o_fs_start, // Pulse: float-switch start.
	output logic [NCH-1:0] o_mon_start, // Pulse: monitor start.
	output logic [NCH-1:0] o_amp_cut, // Amplifier current cut.
	output logic [NCH-1:0][4:0] o_chain_steps, // Step count 1..16.
	output logic [NCH-1:0][7:0] o_fs_delay, // Float-switch delay.
	output logic [NCH-1:0] o_pin_is_mon, // Pin shows current monitor.
	output logic [NCH-1:0] o_pin_short_flag, // Pin shows short flag.
	output logic [NCH-1:0] o_ov_flag, // Overvoltage flag.
	output logic [NCH-1:0] o_gate_hold // Gate drivers held low.
);
	// ****************************************************************
	// Serial frame handling
	// ****************************************************************
	logic frame_valid;
	logic [15:0] frame_word;
	logic [15:0] tx_ff;
	logic [7:0] spread_ff;
	logic [7:0] dvc_ff;
	logic srst_ff;
	logic clrl_ff;
	logic [NCH-1:0] ov_ff;
	logic [NCH-1:0][7:0] rd_setup;
	logic [NCH-1:0][7:0] rd_delay;
	logic [NCH-1:0][7:0] rd_mon;

	ldcr_spi_slave u_spi
	(
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_sclk(i_sclk),
		.i_csn(i_csn),
		.i_sdi(i_sdi),
		.i_tx_word(tx_ff),
		.o_sdo(o_sdo),
		.o_sdo_oe(o_sdo_oe),
		.o_frame_valid(frame_valid),
		.o_frame_word(frame_word)
	);

	wire is_write = frame_word[15];
	wire [6:0] addr = frame_word[14:8];
	wire [7:0] wdata = frame_word[7:0];
	wire wr_any = frame_valid & is_write;
	wire rd_any = frame_valid & ~is_write;

	// ****************************************************************
	// Address decode
	// ****************************************************************
	wire hit_spread = (addr == `LDCR_ADDR_SPREAD);
	wire hit_dvc = (addr == `LDCR_ADDR_DVC);
	wire [NCH-1:0] hit_fss;
	wire [NCH-1:0] hit_fsd;
	wire [NCH-1:0] hit_mon;
	assign hit_fss[0] = (addr == `LDCR_ADDR_FSS_CH0);
	assign hit_fsd[0] = (addr == `LDCR_ADDR_FSD_CH0);
	assign hit_mon[0] = (addr == `LDCR_ADDR_MON_CH0);
	assign hit_fss[1] = (addr == `LDCR_ADDR_FSS_CH1);
	assign hit_fsd[1] = (addr == `LDCR_ADDR_FSD_CH1);
	assign hit_mon[1] = (addr == `LDCR_ADDR_MON_CH1);
	wire hit_any = hit_spread | hit_dvc | (|hit_fss) | (|hit_fsd) |
		(|hit_mon);
	wire wr_spread = wr_any & hit_spread;
	wire wr_dvc = wr_any & hit_dvc;
	wire do_srst = wr_dvc & wdata[`LDCR_B_SRST];
	wire do_clrl = wr_dvc & wdata[`LDCR_B_CLRL];

	// ****************************************************************
	// Read data select
	// ****************************************************************
	logic [7:0] rd_data;
	always_comb
	begin
		rd_data = 8'h00;
		if (hit_spread) rd_data = spread_ff;
		if (hit_dvc) rd_data = dvc_ff;
		for (int c = 0; c < NCH; c++)
		begin
			if (hit_fss[c]) rd_data = rd_setup[c];
			if (hit_fsd[c]) rd_data = rd_delay[c];
			if (hit_mon[c]) rd_data = rd_mon[c];
		end
	end
	wire [15:0] diag_word = {8'h00, i_std_diag};
	wire [15:0] nxt_tx = (rd_any & hit_any) ? {1'b0, addr, rd_data} :
		diag_word;

	// ****************************************************************
	// Global registers
	// ****************************************************************
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			spread_ff <= `LDCR_RST_SPREAD;
			dvc_ff <= `LDCR_RST_DVC;
			srst_ff <= 1'b0;
			clrl_ff <= 1'b0;
			tx_ff <= 16'h0000;
		end
		else
		begin
			srst_ff <= do_srst;
			clrl_ff <= do_clrl;
			if (frame_valid) tx_ff <= nxt_tx;
			if (srst_ff)
			begin
				spread_ff <= `LDCR_RST_SPREAD;
				dvc_ff <= `LDCR_RST_DVC;
			end
			else
			begin
				if (wr_spread) spread_ff <= {5'h00, wdata[2:0]};
				// Command bits act once and read back as zero.
				if (wr_dvc) dvc_ff <= {7'h00, wdata[`LDCR_B_IDLE]};
			end
		end
	end

	assign o_spread_en = spread_ff[`LDCR_B_SPEN];
	assign o_spread_dev_pct = spread_ff[`LDCR_B_DEV] ? `LDCR_DEV_NARROW :
		`LDCR_DEV_WIDE;
	assign o_spread_fm_khz = spread_ff[`LDCR_B_RATE] ? `LDCR_FM_FAST :
		`LDCR_FM_SLOW;
	assign o_idle = dvc_ff[`LDCR_B_IDLE];
	assign o_soft_reset = srst_ff;
	assign o_clear_latch = clrl_ff;

	// ****************************************************************
	// Per-channel register copies
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_ch
			ldcr_cfg_if u_if ();
			assign u_if.wr_setup = wr_any & hit_fss[g];
			assign u_if.wr_delay = wr_any & hit_fsd[g];
			assign u_if.wr_mon = wr_any & hit_mon[g];
			assign u_if.srst = srst_ff;
			assign u_if.wdata = wdata;
			assign rd_setup[g] = u_if.rd_setup;
			assign rd_delay[g] = u_if.rd_delay;
			assign rd_mon[g] = u_if.rd_mon;

			ldcr_channel u_ch
			(
				.i_clk_sys(i_clk_sys),
				.i_nrst(i_nrst),
				.bus(u_if.chan),
				.i_fs_done(i_fs_done[g]),
				.i_mon_done(i_mon_done[g]),
				.i_band(i_band[g]),
				.o_fs_start(o_fs_start[g]),
				.o_fs_running(),
				.o_mon_start(o_mon_start[g]),
				.o_amp_cut(o_amp_cut[g]),
				.o_chain_steps(o_chain_steps[g]),
				.o_fs_delay(o_fs_delay[g]),
				.o_pin_is_mon(o_pin_is_mon[g])
			);

			// The short flag needs the topology pin high and pin select low.
			assign o_pin_short_flag[g] = ~o_pin_is_mon[g] &
				i_topology_pin[g] & i_short_det[g];

			// Event wins over the clear so a late fault stays latched.
			always_ff @(posedge i_clk_sys or negedge i_nrst)
			begin
				if (!i_nrst)
					ov_ff[g] <= 1'b0;
				else
					ov_ff[g] <= (i_ov_event[g] & i_ov_latch_en[g]) |
						(ov_ff[g] & ~clrl_ff);
			end
			assign o_ov_flag[g] = ov_ff[g] | i_ov_event[g];
			assign o_gate_hold[g] = ov_ff[g];

			ov_hold_a: assert property (@(posedge i_clk_sys)
				disable iff (!i_nrst)
				(ov_ff[g] & ~clrl_ff) |=> ov_ff[g])
				else $error("Latched overvoltage lost without clear.");
		end
	endgenerate

	// ****************************************************************
	// Checks
	// ****************************************************************
	spread_write_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		(wr_spread & ~srst_ff) |=> spread_ff == {5'h00, $past(wdata[2:0])}
		&& o_spread_en == $past(wdata[2]))
		else $error("Spread write not applied.");
	dev_map_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_spread_dev_pct == (spread_ff[0] ? 5'h0A : 5'h14))
		else $error("Deviation select mismatch.");
	rate_map_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_spread_fm_khz == (spread_ff[1] ? 5'h12 : 5'h0C))
		else $error("Modulation rate mismatch.");
	soft_reset_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		do_srst |=> o_soft_reset ##1 (spread_ff == 8'h04 && !o_idle
		&& !o_soft_reset))
		else $error("Soft reset did not restore defaults.");
	clear_pulse_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		do_clrl |=> o_clear_latch ##1 !o_clear_latch)
		else $error("Clear-latch must be one cycle.");
	idle_write_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		(wr_dvc & ~srst_ff) |=> o_idle == $past(wdata[0]))
		else $error("Idle bit not applied.");
	unmapped_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		(frame_valid & ~hit_any & ~srst_ff) |=> $stable(spread_ff)
		&& $stable(dvc_ff) && tx_ff == {8'h00, $past(i_std_diag)})
		else $error("Unmapped access changed state.");
endmodule : ldcr_top

// >>> verification/ldcr_host_model.sv
// ****************************************
// Serial host model
// ****************************************
module ldcr_host_model
(
	input wire logic i_clk_sys, // System clock.
	input wire logic i_sdo, // Device data out.
	input wire logic i_sdo_oe, // Device drives data out.
	output logic o_sclk, // Serial clock.
	output logic o_csn, // Chip select, active low.
	output logic o_sdi // Serial data to device.
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		o_sclk = 1'b0;
		o_csn = 1'b1;
		o_sdi = 1'b0;
	end

	// Each clock phase lasts three system cycles, so the device sees it.
	// The clock stands low outside frames.
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		int i;
		repeat (3) @(posedge i_clk_sys);
		o_csn <= 1'b0;
		for (i = 15; i >= 0; i--)
		begin
			o_sdi <= w[i];
			repeat (3) @(posedge i_clk_sys);
			// An undriven data line shows the inverse, so it is noticed.
			r[i] = i_sdo_oe ? i_sdo : ~i_sdo;
			o_sclk <= 1'b1;
			repeat (3) @(posedge i_clk_sys);
			o_sclk <= 1'b0;
		end
		repeat (3) @(posedge i_clk_sys);
		o_csn <= 1'b1;
		// Data line no longer carries the last bit once deselected.
		o_sdi <= ~w[0];
		repeat (4) @(posedge i_clk_sys);
	endtask : xfer
endmodule : ldcr_host_model

// >>> verification/tb.sv
`include "ldcr_regs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, nrst, sclk, csn, sdi, sdo, sdo_oe, spread_en, idle, srst, clrl;
	logic [7:0] diag;
	logic [4:0] dev, fm;
	logic [1:0] fs_done, mon_done, ov_ev, ov_en, topo, shdet, fs_start;
	logic [1:0] mon_start, cut, pin_mon, pin_sh, ov_flag, gate_hold;
	logic [1:0][1:0] band;
	logic [1:0][4:0] steps;
	logic [1:0][7:0] dly;
	int miscompares = 0;
	int samples_checked = 0;
	int n_srst = 0;
	int n_clr = 0;
	int n_fs = 0;
	int n_mon = 0;
	logic [6:0] ad [8] = '{`LDCR_ADDR_SPREAD, `LDCR_ADDR_DVC,
		`LDCR_ADDR_FSS_CH0, `LDCR_ADDR_FSD_CH0, `LDCR_ADDR_MON_CH0,
		`LDCR_ADDR_FSS_CH1, `LDCR_ADDR_FSD_CH1, `LDCR_ADDR_MON_CH1};
	logic [7:0] rv [8] = '{8'h04, 8'h00, 8'h02, 8'h80, 8'h00, 8'h02,
		8'h80, 8'h00};

	ldcr_top uut (.i_clk_sys(clk), .i_nrst(nrst), .i_sclk(sclk),
		.i_csn(csn), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
		.i_std_diag(diag), .o_spread_en(spread_en),
		.o_spread_dev_pct(dev), .o_spread_fm_khz(fm), .o_idle(idle),
		.o_soft_reset(srst), .o_clear_latch(clrl), .i_fs_done(fs_done),
		.i_mon_done(mon_done), .i_band(band), .i_ov_event(ov_ev),
		.i_ov_latch_en(ov_en), .i_topology_pin(topo),
		.i_short_det(shdet), .o_fs_start(fs_start),
		.o_mon_start(mon_start), .o_amp_cut(cut), .o_chain_steps(steps),
		.o_fs_delay(dly), .o_pin_is_mon(pin_mon),
		.o_pin_short_flag(pin_sh), .o_ov_flag(ov_flag),
		.o_gate_hold(gate_hold));
	ldcr_host_model host (.i_clk_sys(clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe),
		.o_sclk(sclk), .o_csn(csn), .o_sdi(sdi));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Pulses last one cycle, so they are counted rather than polled.
	always @(posedge clk)
	begin
		n_srst += int'(srst === 1'b1);
		n_clr += int'(clrl === 1'b1);
		n_fs += int'(fs_start[0] === 1'b1);
		n_mon += int'(mon_start[0] === 1'b1);
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask : check

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [15:0] r;
		host.xfer({1'b1, a, d}, r);
		repeat (3) @(posedge clk);
	endtask : wr

	// The answer to a read arrives in the following frame.
	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		logic [15:0] r;
		host.xfer({1'b0, a, 8'h00}, r);
		host.xfer({1'b0, 7'h7F, 8'h00}, r);
		check(r, {1'b0, a, exp});
	endtask : rd

	task automatic pulse_done(input bit mon);
		@(posedge clk);
		if (mon)
			mon_done[0] <= 1'b1;
		else
			fs_done[0] <= 1'b1;
		@(posedge clk);
		mon_done <= 2'b00;
		fs_done <= 2'b00;
		repeat (2) @(posedge clk);
	endtask : pulse_done

	task automatic wrap_up();
		$display("miscompares %0d samples_checked %0d", miscompares,
			samples_checked);
		if (miscompares == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		for (int i = 0; i < 8; i++)
			rd(ad[i], rv[i]);
		check(16'({spread_en, dev, fm}), 16'({1'b1, 5'h14, 5'h0C}));
		check(16'(steps), 16'h0042);
		check(dly, 16'h8080);
	endtask : t_reset

	task automatic t_spread();
		logic [2:0] v;
		for (int i = 0; i < 8; i++)
		begin
			v = 3'(i);
			wr(`LDCR_ADDR_SPREAD, {5'h00, v});
			check(16'({spread_en, dev, fm}), 16'({v[2], v[0] ? 5'h0A : 5'h14,
				v[1] ? 5'h12 : 5'h0C}));
		end
	endtask : t_spread

	task automatic t_ctrl();
		int k;
		wr(`LDCR_ADDR_DVC, 8'h01);
		check(16'(idle), 16'h1);
		rd(`LDCR_ADDR_DVC, 8'h01);
		@(posedge clk);
		ov_en <= 2'b01;
		ov_ev <= 2'b01;
		@(posedge clk);
		ov_ev <= 2'b00;
		repeat (3) @(posedge clk);
		check(16'({ov_flag, gate_hold}), 16'h5);
		k = n_clr;
		wr(`LDCR_ADDR_DVC, 8'h05);
		check(16'(n_clr - k), 16'h1);
		check(16'({ov_flag, gate_hold, idle}), 16'h1);
		wr(`LDCR_ADDR_SPREAD, 8'h03);
		k = n_srst;
		wr(`LDCR_ADDR_DVC, 8'h02);
		check(16'(n_srst - k), 16'h1);
		check(16'({spread_en, idle}), 16'h2);
		rd(`LDCR_ADDR_SPREAD, 8'h04);
		ov_en <= 2'b00;
		@(posedge clk);
		ov_ev <= 2'b10;
		@(posedge clk);
		check(16'({ov_flag, gate_hold}), 16'h8);
		ov_ev <= 2'b00;
		repeat (2) @(posedge clk);
		check(16'({ov_flag, gate_hold}), 16'h0);
	endtask : t_ctrl

	task automatic t_steps();
		logic [3:0] s [4] = '{4'h0, 4'h1, 4'h8, 4'hF};
		for (int ch = 0; ch < 2; ch++)
			for (int i = 0; i < 4; i++)
			begin
				wr(ch ? `LDCR_ADDR_FSS_CH1 : `LDCR_ADDR_FSS_CH0, {4'h0, s[i]});
				check(16'(steps[ch]), s[i] == 4'h0 ? 16'h10 : 16'(s[i]));
				check(16'(steps[1 - ch]), ch ? 16'hF : 16'h2);
			end
	endtask : t_steps

	task automatic t_fs();
		int k;
		wr(`LDCR_ADDR_FSS_CH0, 8'h42);
		check(16'(cut), 16'h0);
		k = n_fs;
		wr(`LDCR_ADDR_FSS_CH0, 8'h62);
		check(16'(n_fs - k), 16'h1);
		check(16'(cut), 16'h1);
		rd(`LDCR_ADDR_FSS_CH0, 8'h62);
		pulse_done(1'b0);
		check(16'(cut), 16'h0);
		rd(`LDCR_ADDR_FSS_CH0, 8'h52);
		wr(`LDCR_ADDR_FSS_CH0, 8'h22);
		rd(`LDCR_ADDR_FSS_CH0, 8'h22);
		pulse_done(1'b0);
	endtask : t_fs

	task automatic t_mon();
		int k;
		@(posedge clk);
		band <= {2'b01, 2'b11};
		topo <= 2'b11;
		shdet <= 2'b11;
		rd(`LDCR_ADDR_MON_CH0, 8'h03);
		rd(`LDCR_ADDR_MON_CH1, 8'h01);
		k = n_mon;
		wr(`LDCR_ADDR_MON_CH0, 8'h08);
		check(16'(n_mon - k), 16'h1);
		rd(`LDCR_ADDR_MON_CH0, 8'h0B);
		pulse_done(1'b1);
		rd(`LDCR_ADDR_MON_CH0, 8'h07);
		wr(`LDCR_ADDR_MON_CH0, 8'h18);
		rd(`LDCR_ADDR_MON_CH0, 8'h1B);
		check(16'({pin_mon, pin_sh}), 16'h6);
		pulse_done(1'b1);
		rd(`LDCR_ADDR_MON_CH0, 8'h17);
	endtask : t_mon

	task automatic t_delay();
		wr(`LDCR_ADDR_FSD_CH1, 8'h00);
		check(16'(dly[1]), 16'h00);
		wr(`LDCR_ADDR_FSD_CH1, 8'hFF);
		check(16'(dly), 16'hFF80);
		rd(`LDCR_ADDR_FSD_CH1, 8'hFF);
	endtask : t_delay

	task automatic t_unmapped();
		logic [15:0] r;
		host.xfer({1'b1, 7'h7F, 8'h55}, r);
		host.xfer({1'b0, 7'h7F, 8'h00}, r);
		check(r, {8'h00, diag});
		host.xfer({1'b0, `LDCR_ADDR_SPREAD, 8'h00}, r);
		check(r, {8'h00, diag});
		rd(`LDCR_ADDR_SPREAD, 8'h04);
	endtask : t_unmapped

	initial
	begin
		nrst = 1'b0;
		diag = 8'hA5;
		fs_done = 2'b00;
		mon_done = 2'b00;
		band = '0;
		ov_ev = 2'b00;
		ov_en = 2'b00;
		topo = 2'b00;
		shdet = 2'b00;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_reset();
		t_spread();
		t_ctrl();
		t_steps();
		t_fs();
		t_mon();
		t_delay();
		t_unmapped();
		wrap_up();
	end

	// Seventy-two frames of about a hundred cycles are expected.
	initial
	begin
		repeat (40000) @(posedge clk);
		miscompares++;
		wrap_up();
	end
endmodule : tb
